// file: bau_arbiter.sv
`timescale 1ns/10ps
// Function
// - one idle clock with busy negated between tenures; arbitration overlaps cycles.
// - synchronous apart from the asynchronous reset; otherwise state changes on the rising clock edge only.
// - bus request asserted while an internal access is pending.
// - bus request may be withdrawn at any time, regardless of grant or busy.
// - when already granted, request asserts in the same clock as start.
// - bus request is always actively driven, never wire-ORed.
// - grant removed mid-cycle: finish the cycle, then release the bus.
// - four beats of a burst-inhibited line count as one cycle.
// - bus may be taken away between read and write of locked sequence.
// - sequence-end signal asserted during the final write of a locked sequence.
// - granted while another finishes: wait for busy negated, then assert busy and start.
// - busy held while granted; after grant loss negated at cycle end, then released.
// - request negated when no accesses remain pending.
// - granted with nothing pending: implicit ownership, undefined drive, busy tri-stated.
// - implicit to explicit: busy, request, in-progress and start asserted together.
// - grant held after a cycle: park with busy asserted, undefined drive.
// - five states: idle, snoop, implicit ownership, park, active bus cycle.
// - idle and snoop leave bus undriven and busy undriven, except busy driven high in the first idle clock after release; snoop ready to serve.
// - grant removed late or while parked may still see another cycle.
// - ownership taken only after sampling grant asserted with busy negated.
module bau_arbiter
  import bau_pkg::*;
(
  // clock and reset
  input  wire logic ref_clk,
  input  wire logic rst,
  // internal access request
  input  wire logic req_valid,
  input  wire logic req_line,
  input  wire logic req_lock_last,
  output logic      req_taken,
  output logic      cycle_done,
  // status
  output bau_arb_e  arb_state,
  output logic      snoop_ready,
  // arbitration pins
  output logic      bus_request_n,
  input  wire logic bus_grant_n,
  input  wire logic bus_busy_n_i,
  output logic      bus_busy_n_o,
  output logic      bus_busy_n_oe,
  // transfer control pins
  output logic      transfer_start_n,
  output logic      transfer_in_progress_n,
  output logic      atomic_sequence_end_n,
  input  wire logic transfer_ack_n,
  input  wire logic transfer_error_ack_n,
  // address and data drive control
  output logic      bus_drive_oe,
  output logic      bus_values_defined
);

  bau_state_s s_reg;
  bau_state_s s_next;
  bau_pins_s  pins_raw;
  bau_pins_s  pins;

  logic granted;
  logic other_busy;
  logic bus_free;
  logic ack_seen;
  logic err_seen;
  logic cyc_end;

  assign pins_raw = '{
    grant_n: bus_grant_n,
    busy_n:  bus_busy_n_i,
    ack_n:   transfer_ack_n,
    err_n:   transfer_error_ack_n
  };

  // every pin passes two flops before use
  bau_sync #(
    .W       (BAU_PIN_W),
    .RST_VAL (BAU_PINS_RST)
  ) u_sync (
    .ref_clk (ref_clk),
    .rst     (rst),
    .d       (pins_raw),
    .q       (pins)
  );

  // sampled levels, all active low on the pins
  assign granted  = ~pins.grant_n;
  assign ack_seen = ~pins.ack_n;
  assign err_seen = ~pins.err_n;

  // own busy drive delayed like the synchroniser, so it is not taken for another master
  assign other_busy = ~pins.busy_n & ~s_reg.own_hist[1];
  assign bus_free   = pins.busy_n;

  // final beat reached, or an error ends the cycle early
  assign cyc_end = (s_reg.st == BAU_ACTIVE) & (err_seen |
                   (ack_seen & (s_reg.beats_left == BAU_BEATS_SINGLE)));

  // opens a bus cycle: busy, in-progress and start together, request as well
  function automatic bau_state_s start_cycle(input bau_state_s s,
                                             input logic line,
                                             input logic lock_last);
    bau_state_s r;
    r            = s;
    r.st         = BAU_ACTIVE;
    r.ts_n       = 1'b0;
    r.tip_n      = 1'b0;
    r.bb_out_n   = 1'b0;
    r.bb_oe      = 1'b1;
    r.drv_oe     = 1'b1;
    r.drv_def    = 1'b1;
    r.taken      = 1'b1;
    r.snoop_rdy  = 1'b0;
    r.beats_left = line ? BAU_BEATS_LINE : BAU_BEATS_SINGLE;
    r.atomic_sequence_end_n_n    = ~lock_last;
    return r;
  endfunction

  // gives the bus up: busy driven high for one clock, then released
  function automatic bau_state_s release_bus(input bau_state_s s);
    bau_state_s r;
    r          = s;
    r.st       = BAU_IDLE;
    r.bb_out_n = 1'b1;
    r.bb_oe    = 1'b1;
    r.drv_oe   = 1'b0;
    r.drv_def  = 1'b0;
    r.tip_n    = 1'b1;
    r.atomic_sequence_end_n_n  = 1'b1;
    return r;
  endfunction

  always_comb begin
    s_next          = s_reg;
    s_next.ts_n     = 1'b1;
    s_next.taken    = 1'b0;
    s_next.done     = 1'b0;
    s_next.own_hist = {s_reg.own_hist[0], s_reg.bb_oe & ~s_reg.bb_out_n};
    // request follows pending work and may drop at any time
    s_next.br_n     = ~req_valid;
    unique case (s_reg.st)
      BAU_IDLE, BAU_SNOOP: begin
        // the released busy drive lasts a single clock
        s_next.bb_oe     = 1'b0;
        s_next.drv_oe    = 1'b0;
        s_next.drv_def   = 1'b0;
        s_next.snoop_rdy = 1'b0;
        if (granted && bus_free && !s_reg.bb_oe) begin
          if (req_valid) begin
            s_next = start_cycle(s_next, req_line, req_lock_last);
          end else begin
            s_next.st     = BAU_IMPLICIT;
            s_next.drv_oe = 1'b1;
          end
        end else if (other_busy) begin
          s_next.st        = BAU_SNOOP;
          s_next.snoop_rdy = 1'b1;
        end else begin
          s_next.st = BAU_IDLE;
        end
      end
      BAU_IMPLICIT: begin
        // outputs driven but meaningless, busy left to the pullup
        s_next.bb_oe   = 1'b0;
        s_next.drv_oe  = 1'b1;
        s_next.drv_def = 1'b0;
        if (!granted) begin
          s_next.st     = BAU_IDLE;
          s_next.drv_oe = 1'b0;
        end else if (req_valid) begin
          s_next = start_cycle(s_next, req_line, req_lock_last);
        end
      end
      BAU_ACTIVE: begin
        if (cyc_end) begin
          s_next.done = 1'b1;
          // grant lost during the cycle: finish, then let go
          if (!granted) begin
            // locked sequences are not held: grant loss ends the tenure anyway
            s_next = release_bus(s_next);
          end else begin
            s_next.st      = BAU_PARK;
            s_next.tip_n   = 1'b1;
            s_next.atomic_sequence_end_n_n = 1'b1;
            s_next.drv_def = 1'b0;
          end
        end else if (ack_seen) begin
          // a line stays one cycle until its fourth beat
          s_next.beats_left = s_reg.beats_left - 3'h1;
        end
      end
      BAU_PARK: begin
        // a request seen with a just-removed grant may still start a cycle
        if (!granted) begin
          s_next = release_bus(s_next);
        end else if (req_valid) begin
          s_next = start_cycle(s_next, req_line, req_lock_last);
        end
      end
      default: begin
        s_next = BAU_STATE_RST;
      end
    endcase
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      s_reg <= BAU_STATE_RST;
    end else begin
      s_reg <= s_next;
    end
  end

  assign req_taken              = s_reg.taken;
  assign cycle_done             = s_reg.done;
  assign arb_state              = s_reg.st;
  assign snoop_ready            = s_reg.snoop_rdy;
  assign bus_request_n          = s_reg.br_n;
  assign bus_busy_n_o           = s_reg.bb_out_n;
  assign bus_busy_n_oe          = s_reg.bb_oe;
  assign transfer_start_n       = s_reg.ts_n;
  assign transfer_in_progress_n = s_reg.tip_n;
  assign atomic_sequence_end_n  = s_reg.atomic_sequence_end_n_n;
  assign bus_drive_oe           = s_reg.drv_oe;
  assign bus_values_defined     = s_reg.drv_def;

  // start always comes with in-progress and busy
  a_start_with_tip: assert property (
    @(posedge ref_clk) disable iff (rst)
    !transfer_start_n |-> !transfer_in_progress_n && bus_busy_n_oe && !bus_busy_n_o
  ) else $error("start without in-progress or busy");

  a_start_with_req: assert property (
    @(posedge ref_clk) disable iff (rst)
    !transfer_start_n |-> !bus_request_n
  ) else $error("start without bus request");

  a_take_when_free: assert property (
    @(posedge ref_clk) disable iff (rst)
    ($past(s_reg.st) == BAU_IDLE || $past(s_reg.st) == BAU_SNOOP) &&
    s_reg.st != BAU_IDLE && s_reg.st != BAU_SNOOP
    |-> $past(granted) && $past(bus_free)
  ) else $error("ownership taken without grant and free bus");

  a_release_idle_clk: assert property (
    @(posedge ref_clk) disable iff (rst)
    (s_reg.st == BAU_IDLE) && ($past(s_reg.st) == BAU_ACTIVE ||
     $past(s_reg.st) == BAU_PARK)
    |-> bus_busy_n_oe && bus_busy_n_o ##1 !bus_busy_n_oe
  ) else $error("busy not negated for one clock before release");

  a_line_four_beats: assert property (
    @(posedge ref_clk) disable iff (rst)
    s_reg.st == BAU_ACTIVE && s_reg.beats_left > BAU_BEATS_SINGLE && !err_seen
    |=> s_reg.st == BAU_ACTIVE
  ) else $error("line cycle left before its last beat");

  a_grant_loss_exit: assert property (
    @(posedge ref_clk) disable iff (rst)
    cyc_end && !granted |=> s_reg.st == BAU_IDLE && cycle_done && !bus_drive_oe
  ) else $error("bus kept after grant loss at cycle end");

  a_idle_no_drive: assert property (
    @(posedge ref_clk) disable iff (rst)
    (s_reg.st == BAU_IDLE || s_reg.st == BAU_SNOOP) |-> !bus_drive_oe && bus_busy_n_o
  ) else $error("bus driven while idle or snooping");

  a_implicit_drive: assert property (
    @(posedge ref_clk) disable iff (rst)
    s_reg.st == BAU_IMPLICIT |-> !bus_busy_n_oe && bus_drive_oe && !bus_values_defined
  ) else $error("implicit ownership drive wrong");

  a_park_busy: assert property (
    @(posedge ref_clk) disable iff (rst)
    s_reg.st == BAU_PARK |-> bus_busy_n_oe && !bus_busy_n_o && transfer_in_progress_n
      && !bus_values_defined
  ) else $error("park state drive wrong");

  a_req_released: assert property (
    @(posedge ref_clk) disable iff (rst)
    !req_valid ##1 !req_valid |-> bus_request_n
  ) else $error("request held with nothing pending");

  a_atomic_sequence_end_n_in_cycle: assert property (
    @(posedge ref_clk) disable iff (rst)
    !atomic_sequence_end_n |-> !transfer_in_progress_n && s_reg.st == BAU_ACTIVE
  ) else $error("sequence end outside a bus cycle");

  // per-clock checks on what the pins show
  a_req_follows: assert property (
    @(posedge ref_clk) disable iff (rst)
    req_valid |=> !bus_request_n
  ) else $error("request not raised for pending access");

  a_start_pulse: assert property (
    @(posedge ref_clk) disable iff (rst)
    !transfer_start_n |=> transfer_start_n
  ) else $error("start held longer than one clock");

  a_busy_owned: assert property (
    @(posedge ref_clk) disable iff (rst)
    s_reg.st == BAU_ACTIVE |-> bus_busy_n_oe && !bus_busy_n_o && bus_drive_oe
      && bus_values_defined && !transfer_in_progress_n
  ) else $error("active cycle without busy or defined drive");

  a_park_release: assert property (
    @(posedge ref_clk) disable iff (rst)
    s_reg.st == BAU_PARK && !granted
    |=> s_reg.st == BAU_IDLE && bus_busy_n_oe && bus_busy_n_o && !bus_drive_oe
  ) else $error("park not left with busy negated");

  a_snoop_flag: assert property (
    @(posedge ref_clk) disable iff (rst)
    s_reg.st == BAU_SNOOP |-> snoop_ready && !bus_busy_n_oe && !bus_drive_oe
  ) else $error("snoop state drive or flag wrong");

  a_done_ends_cycle: assert property (
    @(posedge ref_clk) disable iff (rst)
    cycle_done |-> $past(s_reg.st) == BAU_ACTIVE && transfer_in_progress_n
  ) else $error("cycle end flagged outside a bus cycle");

  c_line_done: cover property (
    @(posedge ref_clk) disable iff (rst)
    s_reg.st == BAU_ACTIVE && s_reg.beats_left == BAU_BEATS_LINE ##[1:40] cycle_done
  );

  c_park_to_active: cover property (
    @(posedge ref_clk) disable iff (rst)
    s_reg.st == BAU_PARK ##1 s_reg.st == BAU_ACTIVE
  );

  c_implicit_to_active: cover property (
    @(posedge ref_clk) disable iff (rst)
    s_reg.st == BAU_IMPLICIT ##1 s_reg.st == BAU_ACTIVE
  );

  c_snoop_seen: cover property (
    @(posedge ref_clk) disable iff (rst)
    s_reg.st == BAU_SNOOP
  );

  c_grant_loss: cover property (
    @(posedge ref_clk) disable iff (rst)
    s_reg.st == BAU_ACTIVE && !granted ##[1:40] s_reg.st == BAU_IDLE
  );

endmodule

// file: bau_far_model.sv
`timescale 1ns/10ps
module bau_far_model
  import bau_pkg::*;
(
  // clock and reset
  input  wire logic       ref_clk,
  input  wire logic       rst,
  // scenario control
  input  wire logic       grant_on,
  input  wire logic       am_busy,
  input  wire logic [2:0] beats,
  input  wire logic [2:0] err_beat,
  input  wire logic [1:0] ack_wait,
  // device pins
  input  wire logic       transfer_start_n,
  input  wire logic       bus_busy_n_o,
  input  wire logic       bus_busy_n_oe,
  output logic            bus_grant_n,
  output logic            bus_busy_n,
  output logic            transfer_ack_n,
  output logic            transfer_error_ack_n,
  output logic [2:0]      acks
);
  // pull-up holds busy high when nobody drives it
  assign bus_busy_n = bus_busy_n_oe ? bus_busy_n_o : !am_busy;

  // grant follows the bench; no link to request assumed
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      bus_grant_n <= 1'b1;
    end else begin
      bus_grant_n <= !grant_on;
    end
  end

  // slave answers each beat; error ends the cycle early
  initial begin
    transfer_ack_n <= 1'b1;
    transfer_error_ack_n <= 1'b1;
    acks <= 3'h0;
    forever begin
      @(negedge ref_clk iff (!rst && transfer_start_n === 1'b0));
      acks <= 3'h0;
      for (int i = 1; i <= beats && (err_beat == 0 || i <= err_beat); i++) begin
        repeat (ack_wait) @(posedge ref_clk);
        if (i == err_beat) begin
          transfer_error_ack_n <= 1'b0;
        end else begin
          transfer_ack_n <= 1'b0;
        end
        @(posedge ref_clk);
        transfer_ack_n <= 1'b1;
        transfer_error_ack_n <= 1'b1;
        acks <= acks + 3'h1;
      end
    end
  end
endmodule

// file: bau_pkg.sv
package bau_pkg;

  // arbitration states, binary codes
  typedef enum logic [2:0] {
    BAU_IDLE     = 3'h0,
    BAU_SNOOP    = 3'h1,
    BAU_IMPLICIT = 3'h2,
    BAU_PARK     = 3'h3,
    BAU_ACTIVE   = 3'h4
  } bau_arb_e;

  // transfers per cycle kind
  localparam logic [2:0] BAU_BEATS_LINE   = 3'h4;
  localparam logic [2:0] BAU_BEATS_SINGLE = 3'h1;

  // width of the sampled pin group
  localparam int BAU_PIN_W = 4;

  // sampled bus pins, all active low
  typedef struct packed {
    logic grant_n;
    logic busy_n;
    logic ack_n;
    logic err_n;
  } bau_pins_s;

  // idle level of the sampled pins
  localparam bau_pins_s BAU_PINS_RST = '{
    grant_n: 1'b1, busy_n: 1'b1, ack_n: 1'b1, err_n: 1'b1
  };

  // whole state of the arbitration unit
  typedef struct packed {
    bau_arb_e   st;
    logic [2:0] beats_left;
    logic [1:0] own_hist;
    logic       br_n;
    logic       bb_out_n;
    logic       bb_oe;
    logic       ts_n;
    logic       tip_n;
    logic       atomic_sequence_end_n_n;
    logic       drv_oe;
    logic       drv_def;
    logic       taken;
    logic       done;
    logic       snoop_rdy;
  } bau_state_s;

  localparam bau_state_s BAU_STATE_RST = '{
    st:         BAU_IDLE,
    beats_left: 3'h0,
    own_hist:   2'h0,
    br_n:       1'b1,
    bb_out_n:   1'b1,
    bb_oe:      1'b0,
    ts_n:       1'b1,
    tip_n:      1'b1,
    atomic_sequence_end_n_n:    1'b1,
    drv_oe:     1'b0,
    drv_def:    1'b0,
    taken:      1'b0,
    done:       1'b0,
    snoop_rdy:  1'b0
  };

endpackage

// file: bau_sync.sv
`timescale 1ns/10ps
module bau_sync
  import bau_pkg::*;
#(
  parameter int           W       = 4,
  parameter logic [W-1:0] RST_VAL = '1
) (
  // clock and reset
  input  wire logic         ref_clk,
  input  wire logic         rst,
  // pin side and synchronised side
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } bau_sync_s;

  bau_sync_s s_reg;
  bau_sync_s s_next;

  // first stage feeds only the second
  always_comb begin
    s_next    = s_reg;
    s_next.s1 = d;
    s_next.s2 = s_reg.s1;
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      s_reg <= '{s1: RST_VAL, s2: RST_VAL};
    end else begin
      s_reg <= s_next;
    end
  end

  assign q = s_reg.s2;

endmodule

// file: testbench.sv
`timescale 1ns/10ps
module testbench;
  import bau_pkg::*;
  typedef struct {bau_arb_e fin; logic [2:0] beats; logic lk;} bau_note_s;

  logic       ref_clk, rst, req_valid, req_line, req_lock_last, grant_on, am_busy;
  logic [2:0] beats, err_beat, acks;
  logic [1:0] ack_wait;
  logic       req_taken, cycle_done, snoop_ready, bus_request_n, bus_grant_n, bus_busy_n;
  logic       bus_busy_n_o, bus_busy_n_oe, transfer_start_n, transfer_in_progress_n;
  logic       atomic_sequence_end_n, transfer_ack_n, transfer_error_ack_n;
  logic       bus_drive_oe, bus_values_defined;
  logic       rel = 1'b0;
  bau_arb_e   arb_state;
  bau_note_s  notes[$];
  bau_note_s  nt;
  int         n_mismatch, cmp_count, n_taken;
  logic [31:0] seed, r;

  bau_arbiter dut (.ref_clk(ref_clk), .rst(rst), .req_valid(req_valid), .req_line(req_line),
    .req_lock_last(req_lock_last), .req_taken(req_taken), .cycle_done(cycle_done),
    .arb_state(arb_state), .snoop_ready(snoop_ready), .bus_request_n(bus_request_n),
    .bus_grant_n(bus_grant_n), .bus_busy_n_i(bus_busy_n), .bus_busy_n_o(bus_busy_n_o),
    .bus_busy_n_oe(bus_busy_n_oe), .transfer_start_n(transfer_start_n),
    .transfer_in_progress_n(transfer_in_progress_n),
    .atomic_sequence_end_n(atomic_sequence_end_n), .transfer_ack_n(transfer_ack_n),
    .transfer_error_ack_n(transfer_error_ack_n), .bus_drive_oe(bus_drive_oe),
    .bus_values_defined(bus_values_defined));

  bau_far_model far (.ref_clk(ref_clk), .rst(rst), .grant_on(grant_on), .am_busy(am_busy),
    .beats(beats), .err_beat(err_beat), .ack_wait(ack_wait),
    .transfer_start_n(transfer_start_n), .bus_busy_n_o(bus_busy_n_o),
    .bus_busy_n_oe(bus_busy_n_oe), .bus_grant_n(bus_grant_n), .bus_busy_n(bus_busy_n),
    .transfer_ack_n(transfer_ack_n), .transfer_error_ack_n(transfer_error_ack_n), .acks(acks));

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  task automatic check(input string what, input logic [3:0] seen, input logic [3:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic conclude;
    $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // bounded wait for a pulse; 0 = taken, 1 = done
  task automatic wait_evt(input int which);
    int k;
    k = 0;
    do begin
      @(negedge ref_clk);
      k++;
    end while (((which == 0) ? req_taken : cycle_done) !== 1'b1 && k < 300);
    if (k >= 300) check("pulse", 4'h0, 4'h1);
    @(posedge ref_clk);
  endtask

  task automatic issue(input logic line, input logic lk, input logic [2:0] eb,
                       input bau_arb_e fin);
    bau_note_s n;
    n.fin = fin;
    n.lk = lk;
    n.beats = (eb != 0) ? eb : (line ? BAU_BEATS_LINE : BAU_BEATS_SINGLE);
    notes.push_back(n);
    beats <= line ? BAU_BEATS_LINE : BAU_BEATS_SINGLE;
    err_beat <= eb;
    req_line <= line;
    req_lock_last <= lk;
    req_valid <= 1'b1;
  endtask

  task automatic finish(input logic drop_grant);
    wait_evt(0);
    req_valid <= 1'b0;
    if (drop_grant) grant_on <= 1'b0;
    wait_evt(1);
  endtask

  // result watcher: compares against the oldest note
  always @(negedge ref_clk) begin
    if (rel) check("busy release", bus_busy_n_oe, 4'h0);
    rel = 1'b0;
    if (req_taken === 1'b1) begin
      n_taken++;
      check("start", {transfer_start_n, bus_request_n}, 4'h0);
      check("start tip", transfer_in_progress_n, 4'h0);
      check("busy own", {bus_busy_n_oe, bus_busy_n_o}, 4'h2);
      check("drive", {bus_drive_oe, bus_values_defined}, 4'h3);
      if (notes.size() > 0) check("atomic_sequence_end_n", atomic_sequence_end_n, !notes[0].lk);
    end
    if (cycle_done === 1'b1) begin
      if (notes.size() == 0) check("note", 4'h1, 4'h0);
      else begin
        nt = notes.pop_front();
        check("end state", arb_state, nt.fin);
        check("acks", acks, nt.beats);
        check("end busy oe", bus_busy_n_oe, 4'h1);
        check("end busy", bus_busy_n_o, {3'h0, nt.fin == BAU_IDLE});
        check("end tip", {transfer_in_progress_n, bus_values_defined}, 4'h2);
        rel = (nt.fin == BAU_IDLE);
      end
    end
  end

  initial begin
    #100000;
    n_mismatch++;
    $display("[FAIL] run expected done seen timeout");
    conclude();
  end

  initial begin
    {rst, req_valid, req_line, req_lock_last, grant_on, am_busy} = 6'h20;
    {beats, err_beat, ack_wait} = 8'h21;
    {n_mismatch, cmp_count, n_taken} = '0;
    seed = 32'hB66F7D1A;
    repeat (12) @(posedge ref_clk);
    rst <= 1'b0;
    // request then withdraw with no grant
    req_valid <= 1'b1;
    repeat (4) @(posedge ref_clk);
    @(negedge ref_clk);
    check("request", bus_request_n, 4'h0);
    @(posedge ref_clk);
    req_valid <= 1'b0;
    repeat (3) @(posedge ref_clk);
    @(negedge ref_clk);
    check("withdraw", {bus_request_n, bus_busy_n_oe, bus_drive_oe}, 4'h4);
    check("no start", n_taken[3:0], 4'h0);
    // granted while another master still holds busy
    @(posedge ref_clk);
    am_busy <= 1'b1;
    grant_on <= 1'b1;
    issue(1'b0, 1'b0, 3'h0, BAU_PARK);
    repeat (8) @(posedge ref_clk);
    @(negedge ref_clk);
    check("snoop", {snoop_ready, arb_state}, 4'h9);
    check("waits busy", {n_taken[0], bus_busy_n_oe}, 4'h0);
    @(posedge ref_clk);
    am_busy <= 1'b0;
    finish(1'b0);
    // from park: line, then error ack on beat 2
    ack_wait <= 2'h2;
    issue(1'b1, 1'b0, 3'h0, BAU_PARK);
    finish(1'b0);
    issue(1'b1, 1'b0, 3'h2, BAU_PARK);
    finish(1'b0);
    // locked last write, grant dropped mid-cycle
    ack_wait <= 2'h3;
    issue(1'b1, 1'b1, 3'h0, BAU_IDLE);
    finish(1'b1);
    repeat (3) @(posedge ref_clk);
    // grant with nothing pending gives implicit ownership
    grant_on <= 1'b1;
    repeat (6) @(posedge ref_clk);
    @(negedge ref_clk);
    check("implicit", arb_state, BAU_IMPLICIT);
    check("implicit drv", {bus_busy_n_oe, bus_drive_oe, bus_values_defined}, 4'h2);
    @(posedge ref_clk);
    issue(1'b0, 1'b0, 3'h0, BAU_PARK);
    finish(1'b0);
    // random traffic while parked; grant held through locked writes
    for (int i = 0; i < 8; i++) begin
      r = $random(seed);
      ack_wait <= (r[1:0] == 2'h0) ? 2'h1 : r[1:0];
      issue(r[4], r[5], 3'h0, BAU_PARK);
      finish(1'b0);
    end
    // park released when grant goes away
    grant_on <= 1'b0;
    repeat (6) @(posedge ref_clk);
    @(negedge ref_clk);
    check("released", {arb_state, bus_busy_n_oe}, 4'h0);
    check("count", n_taken[3:0], 4'hD);
    conclude();
  end
endmodule
